// ### src/epv_defs.svh
`ifndef EPV_DEFS_SVH
`define EPV_DEFS_SVH

// Exception numbering
`define EPV_NUM_SYS    16
`define EPV_IRQ_BASE   16
`define EPV_EXC_RESET  1
`define EPV_EXC_NMI    2
`define EPV_EXC_HF     3
`define EPV_EXC_CFG0   4
`define EPV_EXC_PSR    14
`define EPV_EXC_TICK   15
`define EPV_SYS_IMPL   16'hd87c
`define EPV_IRQ_IMPL   30'h31ffc1ff

// Urgency levels, smaller is more urgent
`define EPV_LVL_RESET  4'h0
`define EPV_LVL_NMI    4'h1
`define EPV_LVL_HF     4'h2
`define EPV_LVL_OFS    4'h3
`define EPV_LVL_NONE   4'hf
`define EPV_PRIO_RST   3'h0

// Vector table
`define EPV_VBASE_RST  32'h0000_0000
`define EPV_VBASE_MIN  32'h0000_0100
`define EPV_VBASE_MAX  32'h3fff_ff00
`define EPV_SP_OFS     32'h0000_0000
`define EPV_RST_OFS    32'h0000_0004
`define EPV_IRQ0_OFS   32'h0000_0040

`endif

// ### src/epv_pkg.sv
package epv_pkg;
    typedef logic [3:0] epv_lvl_t;
    typedef logic [2:0] epv_prio_t;
    typedef enum logic [1:0] {
        EPV_BOOT_SP,
        EPV_BOOT_PC,
        EPV_RUN
    } epv_boot_t;
endpackage

// ### src/epv_arb.sv
`timescale 1ns/1ps
`include "epv_defs.svh"
module epv_arb
    import epv_pkg::*;
#(
    parameter int N    = 46,
    parameter int NUMW = 6
) (
    input  wire logic [N-1:0]   req,
    input  wire logic [N*4-1:0] lvl,
    output logic                found,
    output logic [NUMW-1:0]     num,
    output epv_lvl_t            best
);
    // Downward scan with <= leaves the lowest number on a tie
    always_comb begin
        found = 1'b0;
        num   = '0;
        best  = `EPV_LVL_NONE;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i] && lvl[i*4 +: 4] <= best) begin
                found = 1'b1;
                num   = NUMW'(i);
                best  = lvl[i*4 +: 4];
            end
        end
    end
endmodule

// ### src/epv_top.sv
`timescale 1ns/1ps
`include "epv_defs.svh"
module epv_top
    import epv_pkg::*;
#(
    parameter int          NIRQ     = 30,
    parameter logic [29:0] IRQ_IMPL = `EPV_IRQ_IMPL,
    parameter int          NUMW     = 6
) (
    input  wire logic            mclk,
    input  wire logic            rst_n,
    input  wire logic [12:0]     sys_req,
    input  wire logic            pendable_service_request,
    input  wire logic            systick_req,
    input  wire logic [NIRQ-1:0] peripheral_interrupt_n,
    input  wire logic            prio_wr_en,
    input  wire logic            prio_wr_priv,
    input  wire logic [NUMW-1:0] prio_wr_num,
    input  wire logic [2:0]      prio_wr_val,
    input  wire logic            vbase_wr_en,
    input  wire logic            vbase_wr_priv,
    input  wire logic [31:0]     vbase_wr_val,
    input  wire logic            core_accept,
    input  wire logic            core_return,
    output logic                 exc_valid,
    output logic [NUMW-1:0]      exc_num,
    output logic [31:0]          vec_addr,
    output epv_lvl_t             active_lvl,
    output logic [31:0]          vector_base_offset_reg,
    output logic                 vbase_wr_err,
    output logic                 boot_valid,
    output logic [31:0]          boot_addr
);
    localparam int NEXC = `EPV_NUM_SYS + NIRQ;

    epv_prio_t             prio [NEXC];
    logic [NEXC*4-1:0]     lvl_flat;
    logic [NEXC-1:0]       impl_mask;
    logic [NEXC-1:0]       req_vec;
    logic [NEXC-1:0]       pend;
    logic [NEXC-1:0]       act;
    logic [NEXC-1:0]       take_clr;
    logic [NEXC-1:0]       ret_clr;
    logic                  pend_found;
    logic [NUMW-1:0]       pend_num;
    epv_lvl_t              pend_lvl;
    logic                  act_found;
    logic [NUMW-1:0]       act_num;
    epv_lvl_t              act_lvl;
    logic                  take;
    logic                  vbase_ok;
    logic                  next_valid;
    epv_boot_t             st;

    assign impl_mask = {IRQ_IMPL[NIRQ-1:0], `EPV_SYS_IMPL};
    assign take      = core_accept && exc_valid;

    // Request map: system exceptions low, peripherals from 16 up
    always_comb begin
        req_vec                      = '0;
        req_vec[12:0]                = sys_req;
        req_vec[`EPV_EXC_PSR]        = pendable_service_request;
        req_vec[`EPV_EXC_TICK]       = systick_req;
        req_vec[`EPV_IRQ_BASE +: NIRQ] = peripheral_interrupt_n;
        req_vec                      = req_vec & impl_mask;
    end

    // Urgency per exception
    always_comb begin
        for (int e = 0; e < NEXC; e++) begin
            if (e == `EPV_EXC_RESET) begin
                lvl_flat[e*4 +: 4] = `EPV_LVL_RESET;
            end else if (e == `EPV_EXC_NMI) begin
                lvl_flat[e*4 +: 4] = `EPV_LVL_NMI;
            end else if (e == `EPV_EXC_HF) begin
                lvl_flat[e*4 +: 4] = `EPV_LVL_HF;
            end else begin
                lvl_flat[e*4 +: 4] = {1'b0, prio[e]} + `EPV_LVL_OFS;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int e = 0; e < NEXC; e++) begin
                prio[e] <= `EPV_PRIO_RST;
            end
        end else if (prio_wr_en && prio_wr_priv && prio_wr_num >= NUMW'(`EPV_EXC_CFG0)
                     && 32'(prio_wr_num) < NEXC && impl_mask[prio_wr_num]) begin
            prio[prio_wr_num] <= prio_wr_val;
        end
    end

    assign vbase_ok = vbase_wr_en && vbase_wr_priv
                      && vbase_wr_val >= `EPV_VBASE_MIN
                      && vbase_wr_val <= `EPV_VBASE_MAX;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            vector_base_offset_reg <= `EPV_VBASE_RST;
            vbase_wr_err           <= 1'b0;
        end else begin
            if (vbase_ok) begin
                vector_base_offset_reg <= {vbase_wr_val[31:8], 8'h00};
            end
            vbase_wr_err <= vbase_wr_en && !vbase_ok;
        end
    end

    // Boot fetch of stack word then reset handler word
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st         <= EPV_BOOT_SP;
            boot_valid <= 1'b0;
            boot_addr  <= '0;
        end else begin
            case (st)
                EPV_BOOT_SP: begin
                    boot_valid <= 1'b1;
                    boot_addr  <= vector_base_offset_reg + `EPV_SP_OFS;
                    st         <= EPV_BOOT_PC;
                end
                EPV_BOOT_PC: begin
                    boot_addr <= vector_base_offset_reg + `EPV_RST_OFS;
                    st        <= EPV_RUN;
                end
                EPV_RUN: begin
                    boot_valid <= 1'b0;
                end
                default: begin
                    st <= EPV_RUN;
                end
            endcase
        end
    end

    epv_arb #(.N(NEXC), .NUMW(NUMW)) u_pend_arb (
        .req   (pend),
        .lvl   (lvl_flat),
        .found (pend_found),
        .num   (pend_num),
        .best  (pend_lvl)
    );

    // Most urgent active entry is the running handler
    epv_arb #(.N(NEXC), .NUMW(NUMW)) u_act_arb (
        .req   (act),
        .lvl   (lvl_flat),
        .found (act_found),
        .num   (act_num),
        .best  (act_lvl)
    );

    always_comb begin
        take_clr = '0;
        ret_clr  = '0;
        if (take) begin
            take_clr[exc_num] = 1'b1;
        end
        if (core_return && act_found) begin
            ret_clr[act_num] = 1'b1;
        end
    end

    // New request wins over the clear of the same bit
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pend <= '0;
        end else begin
            pend <= (pend & ~take_clr) | req_vec;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            act <= '0;
        end else begin
            act <= (act & ~ret_clr) | take_clr;
        end
    end

    // Blank one cycle after accept or return while state settles
    assign next_valid = pend_found && pend_lvl < act_lvl && !take && !core_return
                        && st == EPV_RUN;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            exc_valid  <= 1'b0;
            exc_num    <= '0;
            vec_addr   <= `EPV_VBASE_RST;
            active_lvl <= `EPV_LVL_NONE;
        end else begin
            exc_valid  <= next_valid;
            exc_num    <= pend_num;
            vec_addr   <= vector_base_offset_reg + {24'h0, pend_num, 2'b00};
            active_lvl <= act_lvl;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_prio_reset_zero: assert property ($past(!rst_n) |-> prio[`EPV_EXC_CFG0] == 3'h0)
        else $error("configurable priority not zero after reset");
    a_vbase_hold: assert property (!$past(vbase_ok) |-> $stable(vector_base_offset_reg))
        else $error("table base moved without a valid write");
    a_vbase_range: assert property (vector_base_offset_reg == `EPV_VBASE_RST
        || (vector_base_offset_reg >= `EPV_VBASE_MIN && vector_base_offset_reg <= `EPV_VBASE_MAX))
        else $error("table base out of range");
    a_vbase_align: assert property (vector_base_offset_reg[7:0] == 8'h00)
        else $error("table base not 256-byte aligned");
    a_vec_addr_calc: assert property (exc_valid |-> vec_addr ==
        $past(vector_base_offset_reg) + {24'h0, exc_num, 2'b00})
        else $error("vector address mismatch");
    a_preempt_strict: assert property (exc_valid |-> $past(pend_lvl) < $past(act_lvl))
        else $error("presented exception not strictly more urgent");
    a_equal_no_preempt: assert property (pend_found && act_found && pend_lvl == act_lvl
        && !take |=> !exc_valid)
        else $error("equal priority preempted");
    a_fixed_levels: assert property (lvl_flat[`EPV_EXC_NMI*4 +: 4] == `EPV_LVL_NMI
        && lvl_flat[`EPV_EXC_HF*4 +: 4] == `EPV_LVL_HF)
        else $error("fixed priority changed");
    a_cfg_lvl_range: assert property (lvl_flat[`EPV_IRQ_BASE*4 +: 4] >= `EPV_LVL_OFS
        && lvl_flat[`EPV_IRQ_BASE*4 +: 4] <= `EPV_LVL_OFS + 4'h7)
        else $error("configurable level out of range");
    a_irq_map: assert property (peripheral_interrupt_n[0] |=> pend[`EPV_IRQ_BASE])
        else $error("peripheral interrupt 0 not pending at 16");
    a_psr_pend: assert property (pendable_service_request |=> pend[`EPV_EXC_PSR])
        else $error("service request not pending at 14");
    a_tie_low: assert property (exc_valid && $past(pend[`EPV_IRQ_BASE])
        && $past(pend[`EPV_IRQ_BASE+1]) && $past(lvl_flat[`EPV_IRQ_BASE*4 +: 4])
        == $past(lvl_flat[(`EPV_IRQ_BASE+1)*4 +: 4]) |-> exc_num != NUMW'(`EPV_IRQ_BASE + 1))
        else $error("tie not broken toward lowest number");
    a_boot_seq: assert property (st == EPV_BOOT_SP |=> boot_valid ##1 boot_valid
        ##1 !boot_valid)
        else $error("boot fetch sequence wrong");

    c_take: cover property (take);
    c_nested: cover property (exc_valid && act_found);
    c_vbase_move: cover property (vbase_ok);
    c_vbase_err: cover property (vbase_wr_err);
endmodule

// ### testbench/epv_core_model.sv
`timescale 1ns/1ps
module epv_core_model
    import epv_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        go,
    input  wire logic [3:0]  dly,
    input  wire logic        exc_valid,
    input  wire logic [5:0]  exc_num,
    input  wire logic [31:0] vec_addr,
    output logic             core_accept,
    output logic [5:0]       taken,
    output logic [31:0]      handler
);
    logic [3:0] cnt;

    // Accepts after dly cycles of presentation, never two cycles running
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            core_accept <= 1'b0;
            cnt         <= 4'h0;
            taken       <= 6'h00;
            handler     <= 32'h0000_0000;
        end else if (core_accept || !(go && exc_valid)) begin
            core_accept <= 1'b0;
            cnt         <= 4'h0;
        end else if (cnt >= dly) begin
            core_accept <= 1'b1;
            taken       <= exc_num;
            // Table word as software stores it: odd handler address
            handler     <= vec_addr | 32'h0000_0001;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// ### testbench/exception_priority_vectoring_tb.sv
`timescale 1ns/1ps
module exception_priority_vectoring_tb;
    import epv_pkg::*;
    logic        mclk, rst_n, pendable_service_request, systick_req, core_return, go;
    logic        prio_wr_en, prio_wr_priv, vbase_wr_en, vbase_wr_priv;
    logic        exc_valid, vbase_wr_err, boot_valid, core_accept;
    logic [12:0] sys_req;
    logic [29:0] pirq;
    logic [5:0]  prio_wr_num, exc_num, taken;
    logic [2:0]  prio_wr_val;
    logic [3:0]  dly;
    logic [31:0] vbase_wr_val, vec_addr, vbase, boot_addr, handler;
    epv_lvl_t    active_lvl;
    int          fails, n_checks, cyc;

    epv_top dut_u (.mclk(mclk), .rst_n(rst_n), .sys_req(sys_req),
        .pendable_service_request(pendable_service_request), .systick_req(systick_req),
        .peripheral_interrupt_n(pirq), .prio_wr_en(prio_wr_en), .prio_wr_priv(prio_wr_priv),
        .prio_wr_num(prio_wr_num), .prio_wr_val(prio_wr_val), .vbase_wr_en(vbase_wr_en),
        .vbase_wr_priv(vbase_wr_priv), .vbase_wr_val(vbase_wr_val), .core_accept(core_accept),
        .core_return(core_return), .exc_valid(exc_valid), .exc_num(exc_num),
        .vec_addr(vec_addr), .active_lvl(active_lvl), .vector_base_offset_reg(vbase),
        .vbase_wr_err(vbase_wr_err), .boot_valid(boot_valid), .boot_addr(boot_addr));
    epv_core_model core_u (.mclk(mclk), .rst_n(rst_n), .go(go), .dly(dly),
        .exc_valid(exc_valid), .exc_num(exc_num), .vec_addr(vec_addr),
        .core_accept(core_accept), .taken(taken), .handler(handler));

    always #2 mclk = ~mclk;

    task print_verdict();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            print_verdict();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task pulse(input logic [12:0] s, input logic p, input logic t, input logic [29:0] q);
        @(posedge mclk) begin
            sys_req <= s;
            pendable_service_request <= p;
            systick_req <= t;
            pirq <= q;
        end
        @(posedge mclk) begin
            sys_req <= 13'h0000;
            pendable_service_request <= 1'b0;
            systick_req <= 1'b0;
            pirq <= 30'h0;
        end
    endtask

    // Waits for presentation, checks it, lets the core model take it
    task take(input logic [5:0] n, input logic [31:0] a, input logic [3:0] d);
        int i;
        for (i = 0; i < 20 && exc_valid !== 1'b1; i++) @(posedge mclk) #1;
        chk(32'(exc_valid), 32'h1);
        chk(32'(exc_num), 32'(n));
        chk(vec_addr, a);
        @(posedge mclk) begin
            dly <= d;
            go <= 1'b1;
        end
        for (i = 0; i < 20 && core_accept !== 1'b1; i++) @(posedge mclk) #1;
        @(posedge mclk) go <= 1'b0;
        chk(32'(taken), 32'(n));
        chk(handler, a | 32'h0000_0001);
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task ret();
        @(posedge mclk) core_return <= 1'b1;
        @(posedge mclk) core_return <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task wprio(input logic [5:0] n, input logic [2:0] v, input logic p);
        @(posedge mclk) begin
            prio_wr_en <= 1'b1;
            prio_wr_num <= n;
            prio_wr_val <= v;
            prio_wr_priv <= p;
        end
        @(posedge mclk) prio_wr_en <= 1'b0;
    endtask

    // Refusal flag stands for exactly the cycle after the write edge
    task wvb(input logic [31:0] v, input logic p, input logic err);
        @(posedge mclk) begin
            vbase_wr_en <= 1'b1;
            vbase_wr_val <= v;
            vbase_wr_priv <= p;
        end
        @(posedge mclk) vbase_wr_en <= 1'b0;
        #1;
        chk(32'(vbase_wr_err), 32'(err));
        @(posedge mclk) #1;
        chk(32'(vbase_wr_err), 32'h0);
    endtask

    task t_boot();
        int i;
        for (i = 0; i < 10 && boot_valid !== 1'b1; i++) @(posedge mclk) #1;
        chk(boot_addr, 32'h0000_0000);
        @(posedge mclk) #1;
        chk(boot_addr, 32'h0000_0004);
        @(posedge mclk) #1;
        chk(32'(boot_valid), 32'h0);
        chk(vbase, 32'h0000_0000);
        chk(32'(active_lvl), 32'hf);
        $display("test boot done");
    endtask

    task t_basic();
        pulse(13'h0, 1'b0, 1'b0, 30'h1);
        take(6'h10, 32'h40, 4'h3);
        chk(32'(active_lvl), 32'h3);
        ret();
        chk(32'(active_lvl), 32'hf);
        $display("test basic done");
    endtask

    task t_tie();
        pulse(13'h0, 1'b0, 1'b0, 30'h3);
        take(6'h10, 32'h40, 4'h0);
        repeat (4) begin
            @(posedge mclk) #1;
            chk(32'(exc_valid), 32'h0);
        end
        ret();
        take(6'h11, 32'h44, 4'h0);
        ret();
        $display("test tie done");
    endtask

    task t_prio();
        wprio(6'h10, 3'h5, 1'b1);
        wprio(6'h11, 3'h2, 1'b1);
        wprio(6'h11, 3'h7, 1'b0);
        wprio(6'h02, 3'h7, 1'b1);
        pulse(13'h0, 1'b0, 1'b0, 30'h3);
        take(6'h11, 32'h44, 4'h0);
        chk(32'(active_lvl), 32'h5);
        pulse(13'h4, 1'b0, 1'b0, 30'h0);
        take(6'h02, 32'h08, 4'h0);
        chk(32'(active_lvl), 32'h1);
        ret();
        chk(32'(active_lvl), 32'h5);
        ret();
        take(6'h10, 32'h40, 4'h0);
        chk(32'(active_lvl), 32'h8);
        ret();
        pulse(13'h0, 1'b1, 1'b0, 30'h0);
        take(6'h0e, 32'h38, 4'h0);
        ret();
        pulse(13'h0, 1'b0, 1'b1, 30'h0);
        take(6'h0f, 32'h3c, 4'h0);
        ret();
        $display("test prio done");
    endtask

    task t_vbase();
        wvb(32'h2000_0100, 1'b0, 1'b1);
        wvb(32'h0000_00f0, 1'b1, 1'b1);
        wvb(32'h3fff_ff01, 1'b1, 1'b1);
        chk(vbase, 32'h0000_0000);
        wvb(32'h3fff_ff00, 1'b1, 1'b0);
        chk(vbase, 32'h3fff_ff00);
        wvb(32'h0000_0100, 1'b1, 1'b0);
        chk(vbase, 32'h0000_0100);
        pulse(13'h0, 1'b0, 1'b0, 30'h2000_0000);
        take(6'h2d, 32'h0000_01b4, 4'h0);
        ret();
        $display("test vbase done");
    endtask

    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        {sys_req, pendable_service_request, systick_req, pirq} = '0;
        {prio_wr_en, prio_wr_priv, prio_wr_num, prio_wr_val} = '0;
        {vbase_wr_en, vbase_wr_priv, vbase_wr_val, core_return, go, dly} = '0;
        fails = 0;
        n_checks = 0;
        cyc = 0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        t_boot();
        t_basic();
        t_tie();
        t_prio();
        t_vbase();
        print_verdict();
    end
endmodule
